// [rtl/wmt_pkg.sv]
// Package with register map, field layout and timing constants.
package wmt_pkg;

  // Register addresses in the special register space.
  localparam logic [7:0] MATCH_TIMER_CONTROL_ADDR = 8'hd2;
  localparam logic [7:0] WATCHDOG_CONTROL_ADDR = 8'hd3;
  localparam logic [7:0] WATCHDOG_COUNT_ADDR = 8'hfd;
  localparam logic [7:0] MATCH_REFERENCE_ADDR = 8'hd1;
  localparam logic [7:0] MATCH_COUNT_ADDR = 8'hd0;

  // Reset values.
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] REFERENCE_RESET = 8'hff;

  // Watchdog control fields.
  localparam int WD_SIG_HI = 7;
  localparam int WD_SIG_LO = 4;
  localparam int WD_SEL_HI = 3;
  localparam int WD_SEL_LO = 2;
  localparam int WD_CLR_COUNT_BIT = 1;
  localparam int WD_CLR_DIV_BIT = 0;
  localparam logic [3:0] WD_DISABLE_SIGNATURE = 4'ha;

  // Match timer control fields.
  localparam int MT_SEL_HI = 7;
  localparam int MT_SEL_LO = 6;
  localparam int MT_MODE_BIT = 4;
  localparam int MT_CLR_COUNT_BIT = 3;
  localparam int MT_IRQ_EN_BIT = 1;
  localparam int MT_PEND_BIT = 0;

  // Prescaler width and the tap bits of each divide ratio.
  localparam int DIV_WIDTH = 12;
  localparam int TAP_4096 = 11;
  localparam int TAP_1024 = 9;
  localparam int TAP_256 = 7;
  localparam int TAP_128 = 6;
  localparam int TAP_8 = 2;

  // Counter bits of interest.
  localparam int WD_STABLE_BIT = 4;
  localparam logic [7:0] COUNT_MAX = 8'hff;
  localparam logic [7:0] COUNT_ONE = 8'h01;

  // Clock select codes.
  typedef enum logic [1:0] {
    SEL_SLOW = 2'b00,
    SEL_MID = 2'b01,
    SEL_FAST = 2'b10,
    SEL_FAST_ALT = 2'b11
  } wmt_sel_t;

  // Register bus request carried as one struct.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } wmt_bus_t;

endpackage

// [rtl/wmt_prescaler.sv]
// Shared free-running divider of the oscillator clock with tick outputs.
`timescale 1ns/1ps
module wmt_prescaler (
  sys_clk,
  rst,
  clear,
  wd_sel,
  mt_sel,
  wd_tick,
  mt_tick
);
  import wmt_pkg::*;
  input wire logic sys_clk;
  input wire logic rst;
  input wire logic clear;
  input wire logic [1:0] wd_sel;
  input wire logic [1:0] mt_sel;
  output logic wd_tick;
  output logic mt_tick;

  logic [DIV_WIDTH-1:0] div;
  logic [DIV_WIDTH-1:0] next_div;
  logic [DIV_WIDTH-1:0] rise;
  logic next_wd_tick;
  logic next_mt_tick;

  // Divider advances each clock; a tick marks a rising divider bit.
  always_comb begin
    next_div = clear ? '0 : div + {{(DIV_WIDTH-1){1'b0}}, 1'b1};
    rise = next_div & ~div;
    case (wd_sel)
      SEL_SLOW: next_wd_tick = rise[TAP_4096];
      SEL_MID: next_wd_tick = rise[TAP_1024];
      default: next_wd_tick = rise[TAP_128];
    endcase
    case (mt_sel)
      SEL_SLOW: next_mt_tick = rise[TAP_4096];
      SEL_MID: next_mt_tick = rise[TAP_256];
      default: next_mt_tick = rise[TAP_8];
    endcase
  end

  // Registers only.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      div <= '0;
      wd_tick <= 1'b0;
      mt_tick <= 1'b0;
    end else begin
      div <= next_div;
      wd_tick <= next_wd_tick & ~clear;
      mt_tick <= next_mt_tick & ~clear;
    end
  end
endmodule

// [rtl/wmt_match_counter.sv]
// Eight-bit match timer counter with comparator and PWM output.
`timescale 1ns/1ps
module wmt_match_counter (
  sys_clk,
  rst,
  tick,
  clear,
  pwm_mode,
  reference,
  count,
  match,
  pwm_out
);
  import wmt_pkg::*;
  input wire logic sys_clk;
  input wire logic rst;
  input wire logic tick;
  input wire logic clear;
  input wire logic pwm_mode;
  input wire logic [7:0] reference;
  output logic [7:0] count;
  output logic match;
  output logic pwm_out;

  logic [7:0] next_count;
  logic next_match;
  logic next_pwm_out;

  // Count on each tick; interval mode clears on match, PWM wraps.
  always_comb begin
    next_count = count;
    next_match = 1'b0;
    if (clear) begin
      next_count = COUNT_RESET;
    end else if (tick) begin
      if (count == reference) begin
        next_match = 1'b1;
        next_count = pwm_mode ? count + COUNT_ONE : COUNT_RESET;
      end else begin
        next_count = count + COUNT_ONE;
      end
    end
    // Low while reference is at or below the count.
    next_pwm_out = pwm_mode ? (reference > next_count) : 1'b0;
  end

  // Registers only.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      count <= COUNT_RESET;
      match <= 1'b0;
      pwm_out <= 1'b0;
    end else begin
      count <= next_count;
      match <= next_match;
      pwm_out <= next_pwm_out;
    end
  end
endmodule

// [rtl/wmt_top.sv]
// Watchdog, stabilisation and match timers with their register file.
`timescale 1ns/1ps
module wmt_top (
  sys_clk,
  rst,
  bus,
  stop_release,
  rdata,
  watchdog_reset,
  stabilized,
  cpu_clock_enable,
  match_interrupt,
  pwm_out
);
  import wmt_pkg::*;
  input wire logic sys_clk;
  input wire logic rst;
  input wire wmt_pkg::wmt_bus_t bus;
  input wire logic stop_release;
  output logic [7:0] rdata;
  output logic watchdog_reset;
  output logic stabilized;
  output logic cpu_clock_enable;
  output logic match_interrupt;
  output logic pwm_out;

  logic [7:0] watchdog_control;
  logic [7:0] next_watchdog_control;
  logic [7:0] match_timer_control;
  logic [7:0] next_match_timer_control;
  logic [7:0] match_reference_value;
  logic [7:0] next_match_reference_value;
  logic [7:0] watchdog_count;
  logic [7:0] next_watchdog_count;
  logic [7:0] next_rdata;
  logic next_watchdog_reset;
  logic next_stabilized;
  logic next_match_interrupt;
  logic stop_meta;
  logic stop_sync;
  logic stop_prev;
  logic stabilizing;
  logic next_stabilizing;
  logic wd_write;
  logic mt_write;
  logic wd_tick;
  logic mt_tick;
  logic mt_match;
  logic mt_pwm;
  logic [7:0] mt_count;
  logic stop_edge;

  // Write strobes of the two control registers.
  assign wd_write = bus.wr && (bus.addr == WATCHDOG_CONTROL_ADDR);
  assign mt_write = bus.wr && (bus.addr == MATCH_TIMER_CONTROL_ADDR);
  assign stop_edge = stop_sync & ~stop_prev;

  // Shared divider with both clock multiplexers.
  wmt_prescaler u_prescaler (
    .sys_clk(sys_clk),
    .rst(rst),
    .clear(wd_write && bus.wdata[WD_CLR_DIV_BIT]),
    .wd_sel(watchdog_control[WD_SEL_HI:WD_SEL_LO]),
    .mt_sel(match_timer_control[MT_SEL_HI:MT_SEL_LO]),
    .wd_tick(wd_tick),
    .mt_tick(mt_tick)
  );

  // Match timer counter, comparator and PWM stage.
  wmt_match_counter u_match (
    .sys_clk(sys_clk),
    .rst(rst),
    .tick(mt_tick),
    .clear(mt_write && bus.wdata[MT_CLR_COUNT_BIT]),
    .pwm_mode(match_timer_control[MT_MODE_BIT]),
    .reference(match_reference_value),
    .count(mt_count),
    .match(mt_match),
    .pwm_out(mt_pwm)
  );

  // Control registers; clear bits are strobes and never stored.
  always_comb begin
    next_watchdog_control = watchdog_control;
    next_match_timer_control = match_timer_control;
    next_match_reference_value = match_reference_value;
    if (wd_write) begin
      next_watchdog_control = bus.wdata;
      next_watchdog_control[WD_CLR_COUNT_BIT] = 1'b0;
      next_watchdog_control[WD_CLR_DIV_BIT] = 1'b0;
    end
    if (mt_write) begin
      next_match_timer_control = bus.wdata;
      next_match_timer_control[MT_CLR_COUNT_BIT] = 1'b0;
      // Pending bit: software may only clear it.
      next_match_timer_control[MT_PEND_BIT] =
        match_timer_control[MT_PEND_BIT] & bus.wdata[MT_PEND_BIT];
    end
    if (bus.wr && (bus.addr == MATCH_REFERENCE_ADDR)) begin
      next_match_reference_value = bus.wdata;
    end
    // A match sets the pending flag and wins over a clear.
    if (mt_match) begin
      next_match_timer_control[MT_PEND_BIT] = 1'b1;
    end
  end

  // Watchdog count, overflow reset and stabilisation window.
  always_comb begin
    next_watchdog_count = watchdog_count;
    next_watchdog_reset = 1'b0;
    next_stabilizing = stabilizing;
    if (stop_edge) begin
      // Restart stabilisation with the preset clock select.
      next_watchdog_count = COUNT_RESET;
      next_stabilizing = 1'b1;
    end else if (wd_write && bus.wdata[WD_CLR_COUNT_BIT]) begin
      next_watchdog_count = COUNT_RESET;
    end else if (wd_tick) begin
      next_watchdog_count = watchdog_count + COUNT_ONE;
      if (watchdog_count == COUNT_MAX) begin
        // Overflow out of bit 7.
        next_watchdog_reset = watchdog_control[WD_SIG_HI:WD_SIG_LO]
          != WD_DISABLE_SIGNATURE;
      end
    end
    if (next_watchdog_count[WD_STABLE_BIT]) begin
      next_stabilizing = 1'b0;
    end
    next_stabilized = ~next_stabilizing;
  end

  // Read data mux; the watchdog count is visible but never written.
  always_comb begin
    case (bus.addr)
      WATCHDOG_CONTROL_ADDR: next_rdata = watchdog_control;
      MATCH_TIMER_CONTROL_ADDR: next_rdata = match_timer_control;
      MATCH_REFERENCE_ADDR: next_rdata = match_reference_value;
      WATCHDOG_COUNT_ADDR: next_rdata = watchdog_count;
      MATCH_COUNT_ADDR: next_rdata = mt_count;
      default: next_rdata = 8'h00;
    endcase
    if (!bus.rd) begin
      next_rdata = 8'h00;
    end
  end

  // Interrupt request is the enabled pending flag.
  always_comb begin
    next_match_interrupt = next_match_timer_control[MT_IRQ_EN_BIT]
      & next_match_timer_control[MT_PEND_BIT];
  end

  // Registers only.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      watchdog_control <= CONTROL_RESET;
      match_timer_control <= CONTROL_RESET;
      match_reference_value <= REFERENCE_RESET;
      watchdog_count <= COUNT_RESET;
      stabilizing <= 1'b1;
      stabilized <= 1'b0;
      cpu_clock_enable <= 1'b0;
      watchdog_reset <= 1'b0;
      match_interrupt <= 1'b0;
      rdata <= 8'h00;
      pwm_out <= 1'b0;
      stop_meta <= 1'b0;
      stop_sync <= 1'b0;
      stop_prev <= 1'b0;
    end else begin
      watchdog_control <= next_watchdog_control;
      match_timer_control <= next_match_timer_control;
      match_reference_value <= next_match_reference_value;
      watchdog_count <= next_watchdog_count;
      stabilizing <= next_stabilizing;
      stabilized <= next_stabilized;
      cpu_clock_enable <= next_stabilized;
      watchdog_reset <= next_watchdog_reset;
      match_interrupt <= next_match_interrupt;
      rdata <= next_rdata;
      pwm_out <= mt_pwm;
      stop_meta <= stop_release;
      stop_sync <= stop_meta;
      stop_prev <= stop_sync;
    end
  end
endmodule

// [sim/wmt_top_chk.sv]
// Port checker for the watchdog and match timer block.
`timescale 1ns/1ps
module wmt_top_chk (
  sys_clk,
  rst,
  bus,
  stop_release,
  rdata,
  watchdog_reset,
  stabilized,
  cpu_clock_enable,
  match_interrupt,
  pwm_out
);
  import wmt_pkg::*;
  input wire logic sys_clk;
  input wire logic rst;
  input wire wmt_pkg::wmt_bus_t bus;
  input wire logic stop_release;
  input wire logic [7:0] rdata;
  input wire logic watchdog_reset;
  input wire logic stabilized;
  input wire logic cpu_clock_enable;
  input wire logic match_interrupt;
  input wire logic pwm_out;
  logic wd_off;
  logic next_wd_off;
  logic d1_wr;
  logic d2_wr;
  logic d3_wr;
  // Decode writes to the reference and control registers.
  assign d1_wr = bus.wr && bus.addr == MATCH_REFERENCE_ADDR;
  assign d2_wr = bus.wr && bus.addr == MATCH_TIMER_CONTROL_ADDR;
  assign d3_wr = bus.wr && bus.addr == WATCHDOG_CONTROL_ADDR;
  // Remember whether the last watchdog control write held the signature.
  always_comb begin
    next_wd_off = wd_off;
    if (d3_wr) begin
      next_wd_off = bus.wdata[7:4] == WD_DISABLE_SIGNATURE;
    end
  end
  always_ff @(posedge sys_clk) begin
    wd_off <= next_wd_off & ~rst;
  end
  default clocking dc @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  // Relations between the requests and the status outputs.
  gate_follow_a:
  assert property (cpu_clock_enable == stabilized)
    else $error("cpu clock enable differs from stabilized");
  reset_quiet_a:
  assert property (disable iff (1'b0) rst |=> !watchdog_reset && !stabilized
    && !match_interrupt && !pwm_out && rdata == 8'h00)
    else $error("outputs not cleared by reset");
  wd_pulse_a:
  assert property (watchdog_reset |=> !watchdog_reset)
    else $error("watchdog reset longer than one cycle");
  wd_quiet_a:
  assert property (wd_off && $past(wd_off) |-> !watchdog_reset)
    else $error("watchdog reset while signature held");
  wd_clear_a:
  assert property (d3_wr && bus.wdata[1] |-> ##2 !watchdog_reset [*8])
    else $error("watchdog reset right after count clear");
  irq_off_a:
  assert property (d2_wr && !bus.wdata[1] |-> ##2 !match_interrupt)
    else $error("match interrupt while disabled");
  pwm_off_a:
  assert property (d2_wr && !bus.wdata[MT_MODE_BIT] |-> ##3 !pwm_out)
    else $error("pwm output active in interval mode");
  ref_read_a:
  assert property (d1_wr ##2 (bus.rd && bus.addr == MATCH_REFERENCE_ADDR)
    |=> rdata == $past(bus.wdata, 3))
    else $error("reference readback differs");
endmodule
bind wmt_top wmt_top_chk u_chk (
  .sys_clk(sys_clk),
  .rst(rst),
  .bus(bus),
  .stop_release(stop_release),
  .rdata(rdata),
  .watchdog_reset(watchdog_reset),
  .stabilized(stabilized),
  .cpu_clock_enable(cpu_clock_enable),
  .match_interrupt(match_interrupt),
  .pwm_out(pwm_out)
);

// [sim/tb_wmt_top.sv]
// Self-checking bench for the watchdog and match timer block.
`timescale 1ns/1ps
module tb_wmt_top;
  import wmt_pkg::*;
  logic sys_clk;
  logic rst;
  wmt_bus_t bus;
  logic stop_release;
  logic [7:0] rdata;
  logic watchdog_reset;
  logic stabilized;
  logic cpu_clock_enable;
  logic match_interrupt;
  logic pwm_out;
  int fails;
  int comparisons;
  int n;
  wmt_top DUT (
    .sys_clk(sys_clk),
    .rst(rst),
    .bus(bus),
    .stop_release(stop_release),
    .rdata(rdata),
    .watchdog_reset(watchdog_reset),
    .stabilized(stabilized),
    .cpu_clock_enable(cpu_clock_enable),
    .match_interrupt(match_interrupt),
    .pwm_out(pwm_out)
  );
  // Free-running 250 MHz clock.
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // Prints the verdict and ends the run.
  task automatic report_and_stop();
    if (fails == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Compares a byte result.
  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Compares a cycle count against a window.
  task automatic chk_n(string what, int lo, int hi, int got);
    comparisons++;
    if (got < lo || got > hi) begin
      fails++;
      $display("Error %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask
  // One register write; strobe high for one edge, then one idle edge.
  task automatic wr(logic [7:0] a, logic [7:0] d);
    bus = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge sys_clk);
    bus.wr = 1'b0;
    @(negedge sys_clk);
  endtask
  // One register read, judged in the cycle after the strobe.
  task automatic rd(logic [7:0] a, string what, logic [7:0] exp);
    bus = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge sys_clk);
    bus.rd = 1'b0;
    chk(what, exp, rdata);
    @(negedge sys_clk);
  endtask
  // Waits for a status output, bounded; a timeout ends the run.
  task automatic wait_sig(int which, int lo, int hi);
    n = 0;
    while (n <= hi && (which == 0 ? watchdog_reset : which == 1 ?
        stabilized : match_interrupt) !== 1'b1) begin
      @(negedge sys_clk);
      n++;
    end
    chk_n($sformatf("wait on output %0d", which), lo, hi, n);
    if (n > hi) begin
      report_and_stop();
    end
  endtask
  // Register values and status right after reset.
  task automatic reset_values();
    rd(MATCH_TIMER_CONTROL_ADDR, "timer control", 8'h00);
    rd(WATCHDOG_CONTROL_ADDR, "watchdog control", 8'h00);
    rd(MATCH_REFERENCE_ADDR, "reference", REFERENCE_RESET);
    rd(8'h55, "unmapped", 8'h00);
    chk("stabilized", 8'h00, {7'h00, stabilized});
  endtask
  // Watchdog at divide 128: clear, read-only count, overflow timing.
  task automatic watchdog_run();
    wr(WATCHDOG_CONTROL_ADDR, 8'h0b);
    rd(WATCHDOG_COUNT_ADDR, "watchdog count", 8'h00);
    wr(WATCHDOG_COUNT_ADDR, 8'h55);
    rd(WATCHDOG_COUNT_ADDR, "count after write", 8'h00);
    rd(WATCHDOG_CONTROL_ADDR, "watchdog control", 8'h08);
    wait_sig(0, 32680, 32712);
    // Regular clears well inside the overflow period must keep it quiet.
    n = 0;
    repeat (2) begin
      wr(WATCHDOG_CONTROL_ADDR, 8'h0a);
      repeat (20000) begin
        @(negedge sys_clk);
        n += int'(watchdog_reset !== 1'b0);
      end
    end
    chk_n("resets while cleared", 0, 0, n);
    wr(WATCHDOG_CONTROL_ADDR, 8'haa);
  endtask
  // Reset stabilisation ended at divide 128; stop release restarts it there.
  task automatic stop_restart();
    chk("stabilized before stop", 8'h01, {7'h00, stabilized});
    stop_release = 1'b1;
    repeat (4) @(negedge sys_clk);
    chk("stabilized restarted", 8'h00, {7'h00, stabilized});
    chk("cpu clock gated", 8'h00, {7'h00, cpu_clock_enable});
    wait_sig(1, 1900, 2070);
    chk("cpu clock on", 8'h01, {7'h00, cpu_clock_enable});
    stop_release = 1'b0;
  endtask
  // Interval mode at divide 8 with reference 3.
  task automatic interval_run();
    wr(WATCHDOG_CONTROL_ADDR, 8'ha9);
    wr(MATCH_REFERENCE_ADDR, 8'h03);
    wr(MATCH_TIMER_CONTROL_ADDR, 8'h8a);
    wait_sig(2, 18, 40);
    rd(MATCH_TIMER_CONTROL_ADDR, "timer control", 8'h83);
    wr(MATCH_TIMER_CONTROL_ADDR, 8'h82);
    chk("interrupt cleared", 8'h00, {7'h00, match_interrupt});
    wait_sig(2, 18, 34);
    wr(MATCH_TIMER_CONTROL_ADDR, 8'h80);
    chk("interrupt off", 8'h00, {7'h00, match_interrupt});
  endtask
  // PWM mode at divide 8 with reference 40h over two periods.
  task automatic pwm_run();
    wr(MATCH_REFERENCE_ADDR, 8'h40);
    rd(MATCH_REFERENCE_ADDR, "reference", 8'h40);
    wr(MATCH_TIMER_CONTROL_ADDR, 8'h90);
    n = 0;
    repeat (4096) begin
      @(negedge sys_clk);
      n += int'(pwm_out === 1'b1);
    end
    chk_n("pwm high cycles", 1015, 1033, n);
    wr(MATCH_TIMER_CONTROL_ADDR, 8'h92);
    wait_sig(2, 0, 2100);
    wr(MATCH_TIMER_CONTROL_ADDR, 8'h02);
    @(negedge sys_clk);
    chk("pwm in interval", 8'h00, {7'h00, pwm_out});
  endtask
  // Main sequence.
  initial begin
    fails = 0;
    comparisons = 0;
    rst = 1'b1;
    stop_release = 1'b0;
    bus = '0;
    repeat (10) @(negedge sys_clk);
    rst = 1'b0;
    reset_values();
    watchdog_run();
    stop_restart();
    interval_run();
    pwm_run();
    report_and_stop();
  end
endmodule
